// ==== hw/acal_regs.svh ====
// acal_regs.svh: named constants of the calibration datapath
// assumes inclusion by bare name from the engine and divider sources
// Overview of operation
// - Two-bit mode field picks off, offset-corr/gain-est, both corr, both est.
// - Correction modes load fresh measured coefficients and apply them to codes.
// - Estimation keeps applying last coefficients, factory defaults or earlier corrections.
// - Channels zero to three are calibrated, each with its own rate setting.
// - Full correction drops one frame in 2^(9-rate)+1 per channel while fixed_gain_stage_cal_en is low.
// - System offset coefficient is a 24-bit two's complement value.
// - System gain coefficient is 24-bit unsigned, one integer bit.
// - Result minus system offset, then divided by system gain.
// - Four coefficient sets; channels four to six reuse zero to two.
// - Offset determination makes the zero-scale input yield output code zero.
// - Writing 0x1 runs one fresh conversion, stores offset, exits.
// - Writing 0x3 runs one fresh conversion, stores computed gain, exits.
`ifndef ACAL_REGS_SVH
`define ACAL_REGS_SVH
`define ACAL_SCAL_OFFSET_DET 2'h1
`define ACAL_SCAL_GAIN_DET   2'h3
`define ACAL_RCR_CODE        8'hC3
`define ACAL_SYS_OFF_RST     24'h000000
`define ACAL_SYS_GAIN_RST    24'h800000
`define ACAL_NVM_OFF         24'h000000
`define ACAL_NVM_GAIN        24'h800000
`define ACAL_FRAC_BITS       23
`define ACAL_DIV_STEPS       5'h18
`define ACAL_SAT_POS         24'h7FFFFF
`define ACAL_SAT_NEG         24'h800000
`define ACAL_MAG_MAX         24'hFFFFFF
`define ACAL_SLOT_EXP        4'h9
`define ACAL_SET_ALIAS       3'h4
`endif

// ==== hw/acal_pkg.sv ====
// acal_pkg.sv: types of the calibration datapath
// assumes nothing beyond a SystemVerilog compiler
package acal_pkg;
  typedef enum logic [1:0] {
    bg_cal_off               = 2'h0,
    bg_offset_corr_gain_est  = 2'h1,
    bg_offset_corr_gain_corr = 2'h2,
    bg_offset_est_gain_est   = 2'h3
  } acal_bgmode_t;
  // gray order along idle, arm, conversion, divide
  typedef enum logic [1:0] {
    st_idle = 2'h0,
    st_arm  = 2'h1,
    st_conv = 2'h3,
    st_div  = 2'h2
  } acal_state_t;
  typedef logic [2:0]  acal_odr_t;
  typedef logic [23:0] acal_coef_t;
endpackage

// ==== hw/acal_div_if.sv ====
// acal_div_if.sv: request and answer between engine and divider
// assumes one clock shared by both ends
`timescale 1ns/1ps
interface acal_div_if;
  logic               start;
  logic signed [24:0] num;
  logic        [23:0] den;
  logic               busy;
  logic               done;
  logic        [23:0] mag;
  logic               neg;
  modport req (output start, num, den, input busy, done, mag, neg);
  modport div (input start, num, den, output busy, done, mag, neg);
endinterface

// ==== hw/acal_div.sv ====
// acal_div.sv: restoring divider, |num| * 2^23 / den, saturating
// assumes start is honoured only while busy is low
`timescale 1ns/1ps
`include "acal_regs.svh"
module acal_div (
  // clock, reset, enable
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic clk_en,
  // request and answer
  acal_div_if.div   dif
);
  logic [24:0] m;
  logic        ovf;
  logic [24:0] trial;
  logic        fits;
  logic [23:0] rem;
  logic [23:0] quo;
  logic        inbit;
  logic [4:0]  cnt;
  logic [24:0] m_l;
  logic [23:0] den_l;
  logic        ovf_l;

  assign m = dif.num[24] ? 25'(-dif.num) : 25'(dif.num);
  // quotient reaches 2^24 exactly when |num| >= 2*den; den of zero lands here too
  assign ovf = m >= {dif.den, 1'b0};
  assign trial = {rem, inbit};
  assign fits = trial >= {1'b0, den_l};

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      dif.busy <= 1'b0;
      dif.done <= 1'b0;
      dif.mag <= 24'h000000;
      dif.neg <= 1'b0;
      rem <= 24'h000000;
      quo <= 24'h000000;
      inbit <= 1'b0;
      cnt <= 5'h00;
      m_l <= 25'h0000000;
      den_l <= 24'h000000;
      ovf_l <= 1'b0;
    end else if (clk_en) begin
      dif.done <= 1'b0;
      if (dif.start && !dif.busy) begin
        dif.neg <= dif.num[24];
        m_l <= m;
        den_l <= dif.den;
        ovf_l <= ovf;
        if (ovf) begin
          dif.mag <= `ACAL_MAG_MAX;
          dif.done <= 1'b1;
        end else begin
          dif.busy <= 1'b1;
          rem <= m[24:1];
          inbit <= m[0];
          quo <= 24'h000000;
          cnt <= `ACAL_DIV_STEPS;
        end
      end else if (dif.busy) begin
        rem <= fits ? 24'(trial - {1'b0, den_l}) : trial[23:0];
        quo <= {quo[22:0], fits};
        inbit <= 1'b0;
        cnt <= cnt - 5'h01;
        if (cnt == 5'h01) begin
          dif.busy <= 1'b0;
          dif.done <= 1'b1;
          dif.mag <= {quo[22:0], fits};
        end
      end
    end
  end

  a_div_quotient_exact: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (dif.done && !ovf_l) |-> dif.mag == 24'({m_l, {`ACAL_FRAC_BITS{1'b0}}} / den_l))
    else $error("divider quotient wrong");
endmodule // acal_div

// ==== hw/acal_engine.sv ====
// acal_engine.sv: background and system calibration datapath with determination sequencer
// assumes conversion results arrive far apart compared with the 24-cycle divide
`timescale 1ns/1ps
`include "acal_regs.svh"
module acal_engine (
  // clock, reset, enable
  input  wire logic                   ref_clk,
  input  wire logic                   rst_n,
  input  wire logic                   clk_en,
  // background calibration setup
  input  wire acal_pkg::acal_bgmode_t background_cal_mode_sel,
  input  wire logic                   fixed_gain_stage_cal_en,
  input  wire logic [3:0][2:0]        chan_odr_sel,
  // background measurements from the modulator
  input  wire logic                   bgc_off_valid,
  input  wire logic                   bgc_gain_valid,
  input  wire logic [1:0]             bgc_chan,
  input  wire acal_pkg::acal_coef_t   bgc_off,
  input  wire acal_pkg::acal_coef_t   bgc_gain,
  // conversion frames
  input  wire logic                   conv_start,
  input  wire logic [2:0]             conv_chan,
  input  wire logic                   raw_valid,
  input  wire logic [2:0]             raw_chan,
  input  wire logic [23:0]            raw_code,
  // system calibration control
  input  wire logic                   sys_cal_wr,
  input  wire logic [1:0]             sys_cal_mode_ctrl,
  input  wire logic [1:0]             sys_cal_chan,
  input  wire logic                   rst_wr,
  input  wire logic [7:0]             register_conversion_reset,
  // coefficient access
  input  wire logic                   coef_wr,
  input  wire logic                   coef_is_gain,
  input  wire logic [1:0]             coef_chan,
  input  wire acal_pkg::acal_coef_t   coef_wdata,
  input  wire logic [1:0]             rd_chan,
  output      acal_pkg::acal_coef_t   chan_sys_offset_coef,
  output      acal_pkg::acal_coef_t   chan_sys_gain_coef,
  // results and status
  output      logic                   out_valid,
  output      logic [2:0]             out_chan,
  output      logic [23:0]            out_code,
  output      logic                   gain_slot,
  output      logic                   sys_cal_busy
);
  import acal_pkg::*;

  acal_state_t        state;
  acal_state_t        next_state;
  logic [3:0][23:0]   int_off;
  logic [3:0][23:0]   int_gain;
  logic [3:0][23:0]   sys_off;
  logic [3:0][23:0]   sys_gain;
  logic [9:0]         slot_cnt [4];
  logic [3:0]         slot_hit;
  logic [1:0]         raw_set;
  logic [1:0]         s1_set;
  logic [1:0]         det_chan;
  logic [2:0]         s1_chan;
  logic [2:0]         job_chan;
  logic               s1_valid;
  logic               s1_det;
  logic               det_gain;
  logic               job_det;
  logic               rcr_seen;
  logic               abort;
  logic               drop;
  logic               full_corr;
  logic               off_capture;
  logic [23:0]        s1_x;
  logic [23:0]        next_x;
  logic signed [24:0] ival;
  logic signed [49:0] prod;
  acal_div_if         dif ();

  function automatic logic [23:0] sat24(input logic signed [49:0] v);
    if (v > $signed({26'h0000000, `ACAL_SAT_POS})) begin
      return `ACAL_SAT_POS;
    end else if (v < $signed({{26{1'b1}}, `ACAL_SAT_NEG})) begin
      return `ACAL_SAT_NEG;
    end
    return v[23:0];
  endfunction

  acal_div u_div (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .dif     (dif)
  );

  // ****************************************
  // internal (background) coefficient stage
  // ****************************************
  assign raw_set = (raw_chan >= `ACAL_SET_ALIAS) ? 2'(raw_chan - `ACAL_SET_ALIAS)
                                                 : raw_chan[1:0];
  assign full_corr = background_cal_mode_sel == bg_offset_corr_gain_corr
                     && !fixed_gain_stage_cal_en;
  assign drop = full_corr && slot_hit[raw_set];

  // one frame in 2^(9-rate)+1 is spent on gain calibration for that channel
  for (genvar i = 0; i < 4; i++) begin : g_slot
    assign slot_hit[i] = slot_cnt[i] == 10'h000;
    always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
        slot_cnt[i] <= 10'h000;
      end else if (clk_en && raw_valid && full_corr && raw_set == 2'(i)) begin
        if (slot_hit[i]) begin
          slot_cnt[i] <= 10'(10'h001 << (`ACAL_SLOT_EXP - {1'b0, chan_odr_sel[i]}));
        end else begin
          slot_cnt[i] <= slot_cnt[i] - 10'h001;
        end
      end
    end
  end

  always_comb begin
    ival = $signed({raw_code[23], raw_code}) - $signed({int_off[raw_set][23], int_off[raw_set]});
    prod = ival * $signed({1'b0, int_gain[raw_set]});
    // off mode bypasses the internal stage entirely
    next_x = (background_cal_mode_sel == bg_cal_off) ? raw_code
             : sat24(prod >>> `ACAL_FRAC_BITS);
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      int_off <= {4{`ACAL_NVM_OFF}};
      int_gain <= {4{`ACAL_NVM_GAIN}};
    end else if (clk_en) begin
      // estimation modes simply leave the last values in place
      if (bgc_off_valid && (background_cal_mode_sel == bg_offset_corr_gain_est
          || background_cal_mode_sel == bg_offset_corr_gain_corr)) begin
        int_off[bgc_chan] <= bgc_off;
      end
      if (bgc_gain_valid && background_cal_mode_sel == bg_offset_corr_gain_corr) begin
        int_gain[bgc_chan] <= bgc_gain;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s1_valid <= 1'b0;
      s1_det <= 1'b0;
      s1_x <= 24'h000000;
      s1_chan <= 3'h0;
      s1_set <= 2'h0;
      gain_slot <= 1'b0;
    end else if (clk_en) begin
      s1_valid <= raw_valid && !drop;
      s1_det <= state == st_conv && raw_chan == {1'b0, det_chan};
      s1_x <= next_x;
      s1_chan <= raw_chan;
      s1_set <= raw_set;
      gain_slot <= raw_valid && drop;
    end
  end

  // ****************************************
  // system stage and determination sequencer
  // ****************************************
  assign off_capture = state == st_conv && s1_valid && s1_det && !det_gain;
  assign abort = rst_wr && register_conversion_reset == `ACAL_RCR_CODE && rcr_seen;
  // a result arriving while the divider works is lost; frames are far slower
  assign dif.start = s1_valid && !dif.busy && !off_capture;
  assign dif.num = $signed({s1_x[23], s1_x})
                   - $signed({sys_off[s1_set][23], sys_off[s1_set]});
  assign dif.den = sys_gain[s1_set];

  always_comb begin
    next_state = state;
    case (state)
      st_idle: begin
        if (sys_cal_wr && (sys_cal_mode_ctrl == `ACAL_SCAL_OFFSET_DET
            || sys_cal_mode_ctrl == `ACAL_SCAL_GAIN_DET)) begin
          next_state = st_arm;
        end
      end
      st_arm: begin
        if (conv_start && conv_chan == {1'b0, det_chan}) begin
          next_state = st_conv;
        end
      end
      st_conv: begin
        if (off_capture) begin
          next_state = st_idle;
        end else if (s1_valid && s1_det && dif.start) begin
          next_state = st_div;
        end
      end
      st_div: begin
        if (dif.done && job_det) begin
          next_state = st_idle;
        end
      end
      default: next_state = st_idle;
    endcase
    if (abort) begin
      next_state = st_idle;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state <= st_idle;
      det_chan <= 2'h0;
      det_gain <= 1'b0;
      rcr_seen <= 1'b0;
      sys_cal_busy <= 1'b0;
    end else if (clk_en) begin
      state <= next_state;
      sys_cal_busy <= next_state != st_idle;
      if (state == st_idle && sys_cal_wr) begin
        det_chan <= sys_cal_chan;
        det_gain <= sys_cal_mode_ctrl == `ACAL_SCAL_GAIN_DET;
      end
      // a third code write starts a new pair
      if (rst_wr) begin
        rcr_seen <= register_conversion_reset == `ACAL_RCR_CODE && !rcr_seen;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sys_off <= {4{`ACAL_SYS_OFF_RST}};
      sys_gain <= {4{`ACAL_SYS_GAIN_RST}};
      chan_sys_offset_coef <= `ACAL_SYS_OFF_RST;
      chan_sys_gain_coef <= `ACAL_SYS_GAIN_RST;
    end else if (clk_en) begin
      chan_sys_offset_coef <= sys_off[rd_chan];
      chan_sys_gain_coef <= sys_gain[rd_chan];
      if (coef_wr && coef_is_gain) begin
        sys_gain[coef_chan] <= coef_wdata;
      end else if (coef_wr) begin
        sys_off[coef_chan] <= coef_wdata;
      end
      // hardware fill wins over a software write in the same cycle
      if (off_capture) begin
        sys_off[det_chan] <= s1_x;
      end
      if (dif.done && job_det && !abort) begin
        sys_gain[det_chan] <= dif.mag;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      job_det <= 1'b0;
      job_chan <= 3'h0;
      out_valid <= 1'b0;
      out_chan <= 3'h0;
      out_code <= 24'h000000;
    end else if (clk_en) begin
      out_valid <= dif.done && !job_det;
      if (dif.start) begin
        job_det <= s1_det && det_gain && state == st_conv && !abort;
        job_chan <= s1_chan;
      end else if (abort || dif.done) begin
        job_det <= 1'b0;
      end
      if (dif.done && !job_det) begin
        out_chan <= job_chan;
        if (dif.neg) begin
          out_code <= (dif.mag > `ACAL_SAT_NEG) ? `ACAL_SAT_NEG : 24'(-dif.mag);
        end else begin
          out_code <= (dif.mag > `ACAL_SAT_POS) ? `ACAL_SAT_POS : dif.mag;
        end
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_off_mode_bypass: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en && raw_valid && background_cal_mode_sel == bg_cal_off) |=> s1_x == $past(raw_code))
    else $error("off mode altered the code");
  a_est_holds_coef: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (background_cal_mode_sel == bg_offset_est_gain_est) |=> $stable(int_off) && $stable(int_gain))
    else $error("estimation changed a coefficient");
  a_corr_takes_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en && bgc_off_valid && background_cal_mode_sel == bg_offset_corr_gain_corr)
    |=> int_off[$past(bgc_chan)] == $past(bgc_off))
    else $error("corrected offset not taken");
  a_slot_drop_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en && raw_valid && drop) |=> gain_slot && !s1_valid)
    else $error("calibration slot not taken");
  a_alias_set_map: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en && raw_valid && raw_chan == 3'h6) |=> s1_set == 2'h2)
    else $error("channel six not on set two");
  a_off_det_store: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en && off_capture && !abort)
    |=> state == st_idle && sys_off[det_chan] == $past(s1_x))
    else $error("offset determination not stored");
  a_gain_det_exit: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en && state == st_div && dif.done && job_det && !abort) |=> state == st_idle
    && sys_gain[det_chan] == $past(dif.mag))
    else $error("gain determination not finished");
  a_double_abort: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en && rst_wr && register_conversion_reset == `ACAL_RCR_CODE && rcr_seen)
    |=> state == st_idle && !sys_cal_busy)
    else $error("second reset code did not abort");
endmodule // acal_engine

// ==== tb/adc_calibration_engine_tb.sv ====
// adc_calibration_engine_tb.sv: self-checking bench of the calibration engine
// assumes acal_pkg, acal_div_if, acal_div and acal_engine compiled before it
`timescale 1ns/1ps
module adc_calibration_engine_tb;
  import acal_pkg::*;
  // ************
  // stimulus
  // ************
  logic                 ref_clk;
  logic                 rst_n;
  logic                 clk_en;
  acal_bgmode_t         mode;
  logic                 fix_en;
  logic [3:0][2:0]      odr;
  logic                 bo_v;
  logic                 bg_v;
  logic [1:0]           b_ch;
  acal_coef_t           b_off;
  acal_coef_t           b_gain;
  logic                 conv_start;
  logic [2:0]           conv_chan;
  logic                 raw_valid;
  logic [2:0]           raw_chan;
  logic [23:0]          raw_code;
  logic                 sys_cal_wr;
  logic [1:0]           sc_mode;
  logic [1:0]           sc_chan;
  logic                 rst_wr;
  logic [7:0]           rst_code;
  logic                 coef_wr;
  logic                 coef_is_gain;
  logic [1:0]           coef_chan;
  acal_coef_t           coef_wdata;
  logic [1:0]           rd_chan;
  acal_coef_t           off_q;
  acal_coef_t           gain_q;
  logic                 out_valid;
  logic [2:0]           out_chan;
  logic [23:0]          out_code;
  logic                 gain_slot;
  logic                 busy;
  int                   n_errors;
  int                   n_tests;
  // ************
  // device under test
  // ************
  acal_engine u_acal_engine (
    .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
    .background_cal_mode_sel(mode), .fixed_gain_stage_cal_en(fix_en), .chan_odr_sel(odr),
    .bgc_off_valid(bo_v), .bgc_gain_valid(bg_v), .bgc_chan(b_ch), .bgc_off(b_off),
    .bgc_gain(b_gain), .conv_start(conv_start), .conv_chan(conv_chan),
    .raw_valid(raw_valid), .raw_chan(raw_chan), .raw_code(raw_code),
    .sys_cal_wr(sys_cal_wr), .sys_cal_mode_ctrl(sc_mode), .sys_cal_chan(sc_chan),
    .rst_wr(rst_wr), .register_conversion_reset(rst_code), .coef_wr(coef_wr),
    .coef_is_gain(coef_is_gain), .coef_chan(coef_chan), .coef_wdata(coef_wdata),
    .rd_chan(rd_chan), .chan_sys_offset_coef(off_q), .chan_sys_gain_coef(gain_q),
    .out_valid(out_valid), .out_chan(out_chan), .out_code(out_code),
    .gain_slot(gain_slot), .sys_cal_busy(busy)
  );
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // ************
  // shared tasks
  // ************
  task automatic give_verdict;
    if (n_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string msg);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic ran_out;
    n_errors++;
    $display("Error at %0t: wait ran out", $time);
    give_verdict;
  endtask
  // reset also clears the per-set drop counters, so every case that calls it starts alike
  task automatic do_reset(input acal_bgmode_t m, input logic f);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    mode <= m;
    fix_en <= f;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
  endtask
  task automatic wcoef(input logic g, input logic [1:0] ch, input acal_coef_t d);
    @(posedge ref_clk);
    coef_wr <= 1'b1;
    coef_is_gain <= g;
    coef_chan <= ch;
    coef_wdata <= d;
    @(posedge ref_clk);
    coef_wr <= 1'b0;
  endtask
  task automatic rcoef(input logic [1:0] ch, input acal_coef_t eo, input acal_coef_t eg);
    @(posedge ref_clk);
    rd_chan <= ch;
    repeat (2) @(posedge ref_clk);
    #1;
    check(off_q, eo, "offset coefficient");
    check(gain_q, eg, "gain coefficient");
  endtask
  task automatic bgc(input logic [1:0] ch, input acal_coef_t o, input acal_coef_t g);
    @(posedge ref_clk);
    bo_v <= 1'b1;
    bg_v <= 1'b1;
    b_ch <= ch;
    b_off <= o;
    b_gain <= g;
    @(posedge ref_clk);
    bo_v <= 1'b0;
    bg_v <= 1'b0;
  endtask
  // one conversion result; a dropped frame must show gain_slot, and only a kept frame has its code and channel checked
  task automatic frame(input logic [2:0] ch, input logic [23:0] code, input logic drop,
                       input logic [23:0] exp);
    int i;
    @(posedge ref_clk);
    raw_valid <= 1'b1;
    raw_chan <= ch;
    raw_code <= code;
    @(posedge ref_clk);
    raw_valid <= 1'b0;
    for (i = 0; i < 40; i++) begin
      #1;
      if (out_valid === 1'b1 || gain_slot === 1'b1) break;
      @(posedge ref_clk);
    end
    if (i == 40) ran_out;
    check(24'(gain_slot), 24'(drop), "frame dropped");
    if (!drop) check(out_code, exp, "calibrated code");
    if (!drop) check(24'(out_chan), 24'(ch), "result channel");
    repeat (30) @(posedge ref_clk);
  endtask
  task automatic det(input logic [1:0] code, input logic [1:0] ch, input logic [23:0] raw,
                     input logic eb);
    int i;
    logic ov;
    ov = 1'b0;
    @(posedge ref_clk);
    sys_cal_wr <= 1'b1;
    sc_mode <= code;
    sc_chan <= ch;
    @(posedge ref_clk);
    sys_cal_wr <= 1'b0;
    #1;
    check(24'(busy), 24'(eb), "determination busy");
    if (eb) begin
      @(posedge ref_clk);
      conv_start <= 1'b1;
      conv_chan <= {1'b0, ch};
      @(posedge ref_clk);
      conv_start <= 1'b0;
      raw_valid <= 1'b1;
      raw_chan <= {1'b0, ch};
      raw_code <= raw;
      @(posedge ref_clk);
      raw_valid <= 1'b0;
      for (i = 0; i < 50 && busy === 1'b1; i++) begin
        @(posedge ref_clk);
        #1;
        if (out_valid === 1'b1) ov = 1'b1;
      end
      if (i == 50) ran_out;
      check(24'(ov), 24'h000000, "output during determination");
    end
  endtask
  task automatic rst_pulse;
    @(posedge ref_clk);
    rst_wr <= 1'b1;
    rst_code <= 8'hC3;
    @(posedge ref_clk);
    rst_wr <= 1'b0;
  endtask
  // ************
  // scenarios
  // ************
  task automatic sc_system;
    rcoef(2'h1, 24'h000000, 24'h800000);
    wcoef(1'b0, 2'h1, 24'h000100);
    wcoef(1'b1, 2'h1, 24'h400000);
    frame(3'h5, 24'h000300, 1'b0, 24'h000400);
    det(2'h1, 2'h2, 24'h000123, 1'b1);
    rcoef(2'h2, 24'h000123, 24'h800000);
    // software writes back its averaged offset; a single run averages to itself
    wcoef(1'b0, 2'h2, 24'h000123);
    frame(3'h6, 24'h000123, 1'b0, 24'h000000);
    wcoef(1'b1, 2'h2, 24'h200000);
    det(2'h3, 2'h2, 24'h100123, 1'b1);
    rcoef(2'h2, 24'h000123, 24'h400000);
    frame(3'h2, 24'h100123, 1'b0, 24'h200000);
    det(2'h2, 2'h0, 24'h000000, 1'b0);
  endtask
  task automatic sc_abort;
    det(2'h0, 2'h3, 24'h000000, 1'b0);
    @(posedge ref_clk);
    #1;
    check(24'(busy), 24'h000000, "busy after plain request");
    @(posedge ref_clk);
    sys_cal_wr <= 1'b1;
    sc_mode <= 2'h1;
    sc_chan <= 2'h3;
    @(posedge ref_clk);
    sys_cal_wr <= 1'b0;
    rst_pulse;
    repeat (2) @(posedge ref_clk);
    #1;
    check(24'(busy), 24'h000001, "one reset code kept determination");
    rst_pulse;
    repeat (2) @(posedge ref_clk);
    #1;
    check(24'(busy), 24'h000000, "abandoned determination");
    // a conversion on the abandoned channel must now come out as a plain result
    @(posedge ref_clk);
    conv_start <= 1'b1;
    conv_chan <= 3'h3;
    @(posedge ref_clk);
    conv_start <= 1'b0;
    frame(3'h3, 24'h000555, 1'b0, 24'h000555);
    rcoef(2'h3, 24'h000000, 24'h800000);
  endtask
  task automatic sc_background;
    do_reset(bg_offset_corr_gain_est, 1'b0);
    bgc(2'h0, 24'h000010, 24'h400000);
    frame(3'h0, 24'h001010, 1'b0, 24'h001000);
    mode <= bg_offset_est_gain_est;
    bgc(2'h0, 24'h000020, 24'h400000);
    frame(3'h4, 24'h001010, 1'b0, 24'h001000);
    mode <= bg_cal_off;
    frame(3'h0, 24'h001010, 1'b0, 24'h001010);
    do_reset(bg_offset_corr_gain_corr, 1'b0);
    bgc(2'h0, 24'h000000, 24'h400000);
    frame(3'h0, 24'h002000, 1'b1, 24'h000000);
    frame(3'h0, 24'h002000, 1'b0, 24'h001000);
    // fastest rate reloads four, so four kept frames separate two drops
    repeat (3) frame(3'h0, 24'h002000, 1'b0, 24'h001000);
    frame(3'h0, 24'h002000, 1'b1, 24'h000000);
    do_reset(bg_offset_corr_gain_corr, 1'b1);
    frame(3'h0, 24'h002000, 1'b0, 24'h002000);
  endtask
  // ************
  // main sequence
  // ************
  initial begin
    n_errors = 0;
    n_tests = 0;
    rst_n = 1'b0;
    clk_en = 1'b1;
    mode = bg_cal_off;
    fix_en = 1'b0;
    odr = {4{3'h7}};
    bo_v = 1'b0;
    bg_v = 1'b0;
    b_ch = 2'h0;
    b_off = 24'h000000;
    b_gain = 24'h800000;
    conv_start = 1'b0;
    conv_chan = 3'h0;
    raw_valid = 1'b0;
    raw_chan = 3'h0;
    raw_code = 24'h000000;
    sys_cal_wr = 1'b0;
    sc_mode = 2'h0;
    sc_chan = 2'h0;
    rst_wr = 1'b0;
    rst_code = 8'h00;
    coef_wr = 1'b0;
    coef_is_gain = 1'b0;
    coef_chan = 2'h0;
    coef_wdata = 24'h000000;
    rd_chan = 2'h0;
    do_reset(bg_cal_off, 1'b0);
    sc_system;
    sc_abort;
    sc_background;
    give_verdict;
  end
endmodule // adc_calibration_engine_tb
